// >>> core/ddst_pkg.sv
// Constants and state types for the debug serial time-out and single-step block
`default_nettype none
package ddst_pkg;
    // *****************************************
    // Serial timing, in serial debug clock cycles
    // *****************************************
    localparam logic [9:0] SYNC_LOW_CYC = 10'h080;
    localparam logic [9:0] TIMEOUT_CYC = 10'h200;
    localparam logic [9:0] SYNC_DLY_CYC = 10'h010;
    localparam logic [9:0] ACK_DLY_CYC = 10'h010;
    localparam logic [9:0] ACK_LOW_CYC = 10'h010;
    localparam logic [9:0] BIT_SAMPLE_CYC = 10'h00a;
    localparam logic [9:0] SPEEDUP_CYC = 10'h001;
    localparam logic [7:0] SERIAL_DIV = 8'h01;

    // *****************************************
    // State types
    // *****************************************
    typedef enum logic [3:0] {
        L_IDLE,
        L_LOW,
        L_WAIT_HI,
        L_SYNC_DLY,
        L_SYNC_LOW,
        L_SYNC_SPD,
        L_ACK_DLY,
        L_ACK_LOW,
        L_ACK_SPD
    } ddst_link_t;

    typedef enum logic [1:0] {
        S_IDLE,
        S_RUN,
        S_LP
    } ddst_step_t;
endpackage
`default_nettype wire

// >>> core/ddst_core.sv
// Debug serial pin bit receiver, sync answer, ack pulse, time-out and single-step control
`default_nettype none
module ddst_core
    import ddst_pkg::*;
#(
    parameter logic [7:0] CLK_DIV = SERIAL_DIV
) (
    input wire logic clk_in,          // 125 MHz clock
    input wire logic rst_in,          // Synchronous reset, active high
    input wire logic pin_in,          // Debug serial pin level
    output logic pin_out,             // Debug serial pin drive value
    output logic pin_oe_out,          // Debug serial pin drive enable
    output logic rx_bit_out,          // Pulse: one bit received
    output logic rx_val_out,          // Value of last received bit
    output logic soft_rst_out,        // Pulse: partial command discarded
    output logic sync_seen_out,       // Pulse: sync request recognised
    input wire logic partial_in,      // Command or retrieval incomplete
    input wire logic read_wait_in,    // Read issued, data not yet retrieved
    input wire logic ack_req_in,      // Pulse: command done, ack if enabled
    input wire logic hs_on_in,        // Pulse: handshake-enable command
    input wire logic hs_off_in,       // Pulse: handshake-disable command
    output logic hs_en_out,           // Handshake enabled
    input wire logic active_in,       // Processor in active debug mode
    input wire logic step_cmd_in,     // Pulse: single_step_command decoded
    input wire logic irq_pend_in,     // Interrupt pending
    input wire logic instr_done_in,   // Pulse: stepped instruction or stacking done
    input wire logic cpu_lp_in,       // Processor in stop or wait
    input wire logic sys_stop_in,     // System stop mode
    output logic fw_exit_out,         // Pulse: leave debug firmware for one step
    output logic stack_only_out,      // Step performs interrupt stacking only
    output logic dbg_entry_out,       // Pulse: re-enter active debug mode
    output logic vec_entry_out,       // Saved PC is a handler entry
    output logic step_busy_out,       // Single step outstanding
    output logic software_breakpoint_instruction_ok_out,         // Background-entry command allowed
    output logic cmd_ok_out           // Other debug commands allowed
);
    // *****************************************
    // Declarations
    // *****************************************
    ddst_link_t link_ff, nxt_link;
    ddst_step_t step_ff;
    logic [7:0] div_ff;
    logic [9:0] cnt_ff, nxt_cnt;
    logic [9:0] to_cnt_ff;
    logic tick, pin_q_ff, fall, samp_ff, rx_bit_ff, rx_val_ff, sync_ff, to_ff;
    logic hs_ff, ack_pend_ff, rearm_ff, to_run, step_ack;
    logic fw_exit_ff, stack_ff, entry_ff, vec_ff;

    function automatic logic last_cyc(input logic [9:0] cnt, input logic [9:0] lim);
        last_cyc = (cnt == lim - 10'h001);
    endfunction

    // *****************************************
    // Serial clock divider
    // *****************************************
    assign tick = (div_ff == CLK_DIV - 8'h01);

    always_ff @(posedge clk_in) begin
        if (rst_in || tick) begin
            div_ff <= 8'h00;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end

    // *****************************************
    // Pin edge detection
    // *****************************************
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pin_q_ff <= 1'b1;
        end else begin
            pin_q_ff <= pin_in;
        end
    end

    // Own drive is never sensed: falls count only in idle, and not in system stop
    assign fall = pin_q_ff && !pin_in && (link_ff == L_IDLE) && !sys_stop_in;

    // *****************************************
    // Link state machine
    // *****************************************
    always_comb begin
        nxt_link = link_ff;
        nxt_cnt = cnt_ff;
        case (link_ff)
            L_IDLE: begin
                nxt_cnt = 10'h000;
                if (fall) begin
                    nxt_link = L_LOW;
                end else if (ack_pend_ff && !sys_stop_in) begin
                    nxt_link = L_ACK_DLY;
                end
            end
            L_LOW: begin
                if (pin_in) begin
                    nxt_link = L_IDLE;
                end else if (tick) begin
                    if (last_cyc(cnt_ff, SYNC_LOW_CYC)) begin
                        nxt_link = L_WAIT_HI;
                    end
                    nxt_cnt = cnt_ff + 10'h001;
                end
            end
            L_WAIT_HI: begin
                nxt_cnt = 10'h000;
                if (pin_in) begin
                    nxt_link = L_SYNC_DLY;
                end
            end
            L_SYNC_DLY, L_SYNC_LOW, L_SYNC_SPD, L_ACK_DLY, L_ACK_LOW, L_ACK_SPD: begin
                if (tick) begin
                    nxt_cnt = cnt_ff + 10'h001;
                    case (link_ff)
                        L_SYNC_DLY: begin
                            if (last_cyc(cnt_ff, SYNC_DLY_CYC)) begin
                                nxt_link = L_SYNC_LOW;
                                nxt_cnt = 10'h000;
                            end
                        end
                        L_SYNC_LOW: begin
                            if (last_cyc(cnt_ff, SYNC_LOW_CYC)) begin
                                nxt_link = L_SYNC_SPD;
                                nxt_cnt = 10'h000;
                            end
                        end
                        L_ACK_DLY: begin
                            if (last_cyc(cnt_ff, ACK_DLY_CYC)) begin
                                nxt_link = L_ACK_LOW;
                                nxt_cnt = 10'h000;
                            end
                        end
                        L_ACK_LOW: begin
                            if (last_cyc(cnt_ff, ACK_LOW_CYC)) begin
                                nxt_link = L_ACK_SPD;
                                nxt_cnt = 10'h000;
                            end
                        end
                        default: begin
                            if (last_cyc(cnt_ff, SPEEDUP_CYC)) begin
                                nxt_link = L_IDLE;
                                nxt_cnt = 10'h000;
                            end
                        end
                    endcase
                end
            end
            default: begin
                nxt_link = L_IDLE;
                nxt_cnt = 10'h000;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            link_ff <= L_IDLE;
            cnt_ff <= 10'h000;
        end else begin
            link_ff <= nxt_link;
            cnt_ff <= nxt_cnt;
        end
    end

    // *****************************************
    // Bit value and bit/sync pulses
    // *****************************************
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            samp_ff <= 1'b1;
            rx_val_ff <= 1'b0;
            rx_bit_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            rx_bit_ff <= (link_ff == L_LOW) && pin_in;
            sync_ff <= (link_ff == L_LOW) && (nxt_link == L_WAIT_HI);
            if (fall) begin
                samp_ff <= 1'b1;
            end else if ((link_ff == L_LOW) && tick && (cnt_ff == BIT_SAMPLE_CYC)) begin
                samp_ff <= pin_in;
            end
            if ((link_ff == L_LOW) && pin_in) begin
                rx_val_ff <= samp_ff;
            end
        end
    end

    // *****************************************
    // Idle time-out
    // *****************************************
    // Held while a sync request waits for the pin to rise, and while a handshaken read waits for its ack
    assign to_run = partial_in && (link_ff != L_WAIT_HI) && !(hs_ff && read_wait_in && !rearm_ff);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rearm_ff <= 1'b0;
        end else if (!read_wait_in) begin
            rearm_ff <= 1'b0;
        end else if ((link_ff == L_ACK_SPD) && (nxt_link == L_IDLE)) begin
            rearm_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            to_cnt_ff <= 10'h000;
            to_ff <= 1'b0;
        end else begin
            to_ff <= 1'b0;
            if (fall || !to_run || sync_ff) begin
                to_cnt_ff <= 10'h000;
            end else if (tick) begin
                if (last_cyc(to_cnt_ff, TIMEOUT_CYC)) begin
                    to_cnt_ff <= 10'h000;
                    to_ff <= 1'b1;
                end else begin
                    to_cnt_ff <= to_cnt_ff + 10'h001;
                end
            end
        end
    end

    // *****************************************
    // Handshake enable and ack request
    // *****************************************
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hs_ff <= 1'b0;
        end else if (sys_stop_in) begin
            hs_ff <= 1'b0;
        end else if (hs_on_in) begin
            hs_ff <= 1'b1;
        end else if (hs_off_in) begin
            hs_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || sys_stop_in) begin
            ack_pend_ff <= 1'b0;
        end else if (hs_on_in && !sys_stop_in) begin
            ack_pend_ff <= 1'b1;
        end else if (hs_ff && !hs_off_in && (ack_req_in || step_ack)) begin
            ack_pend_ff <= 1'b1;
        end else if ((link_ff == L_IDLE) && (nxt_link == L_ACK_DLY)) begin
            ack_pend_ff <= 1'b0;
        end
    end

    // *****************************************
    // Single-step control
    // *****************************************
    // A step into low power finishes without an ack
    assign step_ack = (step_ff == S_RUN) && !cpu_lp_in && instr_done_in;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            step_ff <= S_IDLE;
            fw_exit_ff <= 1'b0;
            stack_ff <= 1'b0;
            entry_ff <= 1'b0;
            vec_ff <= 1'b0;
        end else begin
            fw_exit_ff <= 1'b0;
            entry_ff <= 1'b0;
            case (step_ff)
                S_IDLE: begin
                    if (step_cmd_in && active_in && !sys_stop_in) begin
                        step_ff <= S_RUN;
                        fw_exit_ff <= 1'b1;
                        stack_ff <= irq_pend_in;
                    end
                end
                S_RUN: begin
                    if (cpu_lp_in) begin
                        step_ff <= S_LP;
                    end else if (instr_done_in) begin
                        step_ff <= S_IDLE;
                        entry_ff <= 1'b1;
                        vec_ff <= stack_ff;
                    end
                end
                S_LP: begin
                    if (!cpu_lp_in) begin
                        step_ff <= S_IDLE;
                        entry_ff <= 1'b1;
                        vec_ff <= 1'b1;
                    end
                end
                default: begin
                    step_ff <= S_IDLE;
                end
            endcase
        end
    end

    // *****************************************
    // Outputs
    // *****************************************
    assign pin_oe_out = (link_ff == L_SYNC_LOW) || (link_ff == L_SYNC_SPD) ||
                        (link_ff == L_ACK_LOW) || (link_ff == L_ACK_SPD);
    assign pin_out = (link_ff == L_SYNC_SPD) || (link_ff == L_ACK_SPD);
    assign rx_bit_out = rx_bit_ff;
    assign rx_val_out = rx_val_ff;
    assign soft_rst_out = to_ff || sync_ff;
    assign sync_seen_out = sync_ff;
    assign hs_en_out = hs_ff;
    assign fw_exit_out = fw_exit_ff;
    assign stack_only_out = stack_ff;
    assign dbg_entry_out = entry_ff;
    assign vec_entry_out = vec_ff;
    assign step_busy_out = (step_ff != S_IDLE);
    assign software_breakpoint_instruction_ok_out = !cpu_lp_in && !sys_stop_in;
    assign cmd_ok_out = !sys_stop_in;
endmodule
`default_nettype wire

// >>> dv/ddst_props.sv
// Concurrent checks on the ports of the debug serial time-out and single-step block
`default_nettype none
module ddst_props (
    input wire logic clk_in, // Clock
    input wire logic rst_in, // Sync reset
    input wire logic pin_in, // Pin level
    input wire logic pin_out, // Drive value
    input wire logic pin_oe_out, // Drive enable
    input wire logic rx_bit_out, // Bit pulse
    input wire logic soft_rst_out, // Soft-reset pulse
    input wire logic sync_seen_out, // Sync pulse
    input wire logic partial_in, // Incomplete
    input wire logic active_in, // Active debug
    input wire logic step_cmd_in, // Step request
    input wire logic irq_pend_in, // Irq pending
    input wire logic cpu_lp_in, // Stop or wait
    input wire logic sys_stop_in, // System stop
    input wire logic fw_exit_out, // Step launch
    input wire logic stack_only_out, // Stacking only
    input wire logic dbg_entry_out, // Debug entry
    input wire logic vec_entry_out, // Handler entry
    input wire logic step_busy_out, // Step open
    input wire logic cmd_ok_out, // Commands allowed
    input wire logic software_breakpoint_instruction_ok_out // Background allowed
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] low_cnt_ff, drv_cnt_ff, gap_cnt_ff;
    logic sync_flag_ff, pin_q_ff;

    // ****************************************
    // Helper counters
    // ****************************************
    always_ff @(posedge clk_in) begin
        pin_q_ff <= rst_in | pin_in;
        low_cnt_ff <= (rst_in || pin_in || pin_oe_out || sys_stop_in) ? 10'h000 : low_cnt_ff + 10'h001;
        drv_cnt_ff <= (rst_in || !pin_oe_out) ? 10'h000 : drv_cnt_ff + {9'h000, !pin_out};
        sync_flag_ff <= !rst_in && !pin_oe_out && (sync_seen_out || sync_flag_ff);
        gap_cnt_ff <= (rst_in || !partial_in || soft_rst_out || (pin_q_ff && !pin_in && !pin_oe_out)) ? 10'h000
            : gap_cnt_ff + {9'h000, gap_cnt_ff != 10'h3ff};
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    property p_sync_late; (low_cnt_ff == 10'h08c) |-> sync_flag_ff; endproperty
    a_sync_late: assert property (p_sync_late) else $error("long low not taken as sync");
    property p_sync_hold; (sync_flag_ff && !pin_in && !pin_oe_out) |-> !soft_rst_out; endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("time-out while waiting after sync");
    property p_sync_wait; (sync_flag_ff && $rose(pin_in)) |-> !pin_oe_out [*8] ##[6:12] (pin_oe_out && !pin_out);
    endproperty
    a_sync_wait: assert property (p_sync_wait) else $error("sync answer delay wrong");
    property p_ans_len; (pin_oe_out && pin_out) |-> (drv_cnt_ff == 10'h080 || drv_cnt_ff == 10'h010); endproperty
    a_ans_len: assert property (p_ans_len) else $error("driven low length wrong");
    property p_spd; (pin_oe_out && pin_out) |=> !pin_oe_out; endproperty
    a_spd: assert property (p_spd) else $error("speedup pulse not one cycle");
    property p_bit; (pin_in && low_cnt_ff != 10'h000 && low_cnt_ff < 10'h07c) |=> rx_bit_out; endproperty
    a_bit: assert property (p_bit) else $error("short low not taken as bit");
    property p_to_early; (soft_rst_out && !sync_seen_out) |-> gap_cnt_ff >= 10'h1f9; endproperty
    a_to_early: assert property (p_to_early) else $error("time-out too early");
    property p_step_go; (step_cmd_in && active_in && !sys_stop_in && !step_busy_out)
        |=> (fw_exit_out && stack_only_out == $past(irq_pend_in)); endproperty
    a_step_go: assert property (p_step_go) else $error("step launch wrong");
    property p_lp_exit; (step_busy_out && cpu_lp_in ##1 !cpu_lp_in && !sys_stop_in)
        |-> ##[0:1] (dbg_entry_out && vec_entry_out); endproperty
    a_lp_exit: assert property (p_lp_exit) else $error("low-power exit entry wrong");
    property p_lp_cmds; (step_busy_out && cpu_lp_in && $past(cpu_lp_in) && !sys_stop_in)
        |-> (cmd_ok_out && !software_breakpoint_instruction_ok_out); endproperty
    a_lp_cmds: assert property (p_lp_cmds) else $error("command gating in stop or wait wrong");
    property p_stop_cmds; sys_stop_in |-> (!cmd_ok_out && !software_breakpoint_instruction_ok_out); endproperty
    a_stop_cmds: assert property (p_stop_cmds) else $error("command accepted in system stop");

    c_sync: cover property (sync_seen_out);
    c_to: cover property (soft_rst_out && !sync_seen_out);
    c_lp: cover property (dbg_entry_out && vec_entry_out);
endmodule
`default_nettype wire

// >>> dv/ddst_host.sv
// Host pod model: pulls the debug serial pin low for timed pulses
`default_nettype none
module ddst_host (
    input wire logic clk_in, // Clock
    output logic drv_low_out // Pull pin low
);
    timeunit 1ns;
    timeprecision 1ps;
    initial drv_low_out = 1'b0;
    // Low for low_cyc, then released; gaps stay under 512 except in the time-out and time-out hold tests
    task automatic pulse(input int low_cyc, input int gap_cyc);
        @(posedge clk_in);
        drv_low_out <= 1'b1;
        repeat (low_cyc) @(posedge clk_in);
        drv_low_out <= 1'b0;
        repeat (gap_cyc) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// >>> dv/ddst_core_tb.sv
// Self-checking bench for the debug serial time-out and single-step block
`default_nettype none
module ddst_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0, rst_in = 1'b1, partial_in = 1'b0, read_wait_in = 1'b0, ack_req_in = 1'b0;
    logic hs_on_in = 1'b0, hs_off_in = 1'b0, active_in = 1'b0, step_cmd_in = 1'b0, irq_pend_in = 1'b0;
    logic instr_done_in = 1'b0, cpu_lp_in = 1'b0, sys_stop_in = 1'b0, host_low, vec_cap = 1'b0;
    logic pin_out, pin_oe_out, rx_bit_out, rx_val_out, soft_rst_out, sync_seen_out, hs_en_out, fw_exit_out;
    logic stack_only_out, dbg_entry_out, vec_entry_out, step_busy_out, software_breakpoint_instruction_ok_out, cmd_ok_out;
    wire logic pin_in;
    int err_count = 0, n_tests = 0, n_bit = 0, n_srst = 0, n_sync = 0, n_spd = 0, n_fw = 0, n_dbg = 0;
    int drv_run = 0, last_len = 0;

    // Open-drain pin with pull-up
    assign pin_in = host_low ? 1'b0 : (pin_oe_out ? pin_out : 1'b1);
    always #4 clk_in = ~clk_in;
    ddst_core u_dut (
        .clk_in(clk_in), .rst_in(rst_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
        .rx_bit_out(rx_bit_out), .rx_val_out(rx_val_out), .soft_rst_out(soft_rst_out),
        .sync_seen_out(sync_seen_out), .partial_in(partial_in), .read_wait_in(read_wait_in),
        .ack_req_in(ack_req_in), .hs_on_in(hs_on_in), .hs_off_in(hs_off_in), .hs_en_out(hs_en_out),
        .active_in(active_in), .step_cmd_in(step_cmd_in), .irq_pend_in(irq_pend_in),
        .instr_done_in(instr_done_in), .cpu_lp_in(cpu_lp_in), .sys_stop_in(sys_stop_in),
        .fw_exit_out(fw_exit_out), .stack_only_out(stack_only_out), .dbg_entry_out(dbg_entry_out),
        .vec_entry_out(vec_entry_out), .step_busy_out(step_busy_out), .software_breakpoint_instruction_ok_out(software_breakpoint_instruction_ok_out),
        .cmd_ok_out(cmd_ok_out)
    );
    ddst_host u_host (.clk_in(clk_in), .drv_low_out(host_low));

    always @(posedge clk_in) begin
        if (rx_bit_out === 1'b1) n_bit <= n_bit + 1;
        if (sync_seen_out === 1'b1) n_sync <= n_sync + 1;
        if (soft_rst_out === 1'b1) n_srst <= n_srst + 1;
        if (fw_exit_out === 1'b1) n_fw <= n_fw + 1;
        if (dbg_entry_out === 1'b1) n_dbg <= n_dbg + 1;
        if (dbg_entry_out === 1'b1) vec_cap <= vec_entry_out;
        drv_run <= (pin_oe_out === 1'b1) ? drv_run + int'(pin_out === 1'b0) : 0;
        if (pin_oe_out === 1'b1 && pin_out === 1'b1) n_spd <= n_spd + 1;
        if (pin_oe_out === 1'b1 && pin_out === 1'b1) last_len <= drv_run;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // One-cycle command strobe: 0 ack, 1 handshake on, 2 handshake off, 3 step, 4 instruction done
    task automatic strobe(input int k);
        ack_req_in <= (k == 0);
        hs_on_in <= (k == 1);
        hs_off_in <= (k == 2);
        step_cmd_in <= (k == 3);
        instr_done_in <= (k == 4);
        tick(1);
        {ack_req_in, hs_on_in, hs_off_in, step_cmd_in, instr_done_in} <= 5'h00;
        tick(1);
    endtask

    task automatic t_serial;
        int b, s, y, p;
        b = n_bit;
        s = n_srst;
        partial_in <= 1'b1;
        u_host.pulse(4, 20);
        check(rx_val_out, 1'b1);
        u_host.pulse(13, 400);
        check(rx_val_out, 1'b0);
        u_host.pulse(4, 520);
        check(n_srst - s, 1);
        u_host.pulse(4, 10);
        check(n_bit - b, 4);
        partial_in <= 1'b0;
        tick(600);
        check(n_srst - s, 1);
        y = n_sync;
        p = n_spd;
        partial_in <= 1'b1;
        u_host.pulse(700, 200);
        check(n_sync - y, 1);
        check(n_srst - s, 2);
        check(n_spd - p, 1);
        check(last_len, 128);
        partial_in <= 1'b0;
    endtask

    task automatic t_hs;
        int s, p;
        p = n_spd;
        check(hs_en_out, 1'b0);
        strobe(0);
        tick(60);
        check(n_spd - p, 0);
        strobe(1);
        tick(60);
        check(hs_en_out, 1'b1);
        check(last_len, 16);
        s = n_srst;
        partial_in <= 1'b1;
        read_wait_in <= 1'b1;
        u_host.pulse(4, 700);
        check(n_srst - s, 0);
        strobe(0);
        tick(600);
        check(n_srst - s, 1);
        check(n_spd - p, 2);
        read_wait_in <= 1'b0;
        strobe(2);
        check(hs_en_out, 1'b0);
        read_wait_in <= 1'b1;
        u_host.pulse(4, 530);
        check(n_srst - s, 2);
        read_wait_in <= 1'b0;
        partial_in <= 1'b0;
    endtask

    task automatic t_step;
        int f, d, p;
        strobe(1);
        tick(60);
        active_in <= 1'b1;
        // Stepped instructions are never the software breakpoint instruction
        for (int i = 0; i < 2; i++) begin
            f = n_fw;
            d = n_dbg;
            p = n_spd;
            irq_pend_in <= i[0];
            strobe(3);
            check(stack_only_out, i[0]);
            strobe(4);
            tick(60);
            check(n_fw - f, 1);
            check(n_dbg - d, 1);
            check(vec_cap, i[0]);
            check(n_spd - p, 1);
        end
        irq_pend_in <= 1'b0;
        d = n_dbg;
        p = n_spd;
        strobe(3);
        cpu_lp_in <= 1'b1;
        tick(3);
        check(step_busy_out, 1'b1);
        check({cmd_ok_out, software_breakpoint_instruction_ok_out}, 2'h2);
        strobe(0);
        tick(60);
        check(n_spd - p, 1);
        sys_stop_in <= 1'b1;
        tick(2);
        check({cmd_ok_out, software_breakpoint_instruction_ok_out}, 2'h0);
        check(hs_en_out, 1'b0);
        sys_stop_in <= 1'b0;
        strobe(1);
        tick(60);
        check(hs_en_out, 1'b1);
        p = n_spd;
        cpu_lp_in <= 1'b0;
        tick(60);
        check(n_dbg - d, 1);
        check(vec_cap, 1'b1);
        check(n_spd - p, 0);
        active_in <= 1'b0;
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        tick(16);
        rst_in <= 1'b0;
        tick(2);
        t_serial;
        t_hs;
        t_step;
        tick(10);
        stop_test;
    end

    initial begin
        tick(20000);
        err_count++;
        stop_test;
    end
endmodule

bind ddst_core ddst_props u_props (
    .clk_in(clk_in), .rst_in(rst_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
    .rx_bit_out(rx_bit_out), .soft_rst_out(soft_rst_out), .sync_seen_out(sync_seen_out),
    .partial_in(partial_in), .active_in(active_in), .step_cmd_in(step_cmd_in), .irq_pend_in(irq_pend_in),
    .cpu_lp_in(cpu_lp_in), .sys_stop_in(sys_stop_in), .fw_exit_out(fw_exit_out),
    .stack_only_out(stack_only_out), .dbg_entry_out(dbg_entry_out), .vec_entry_out(vec_entry_out),
    .step_busy_out(step_busy_out), .cmd_ok_out(cmd_ok_out), .software_breakpoint_instruction_ok_out(software_breakpoint_instruction_ok_out)
);
`default_nettype wire
